// ### core/gdpc_pkg.sv
// Package: register map, field layout, codes and timing counts of the gate protection bank
package gdpc_pkg;

  // Core clock rate used to turn times into cycle counts
  localparam int unsigned CLK_MHZ = 125;

  // Register port address width and register offsets
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] OFS_LSG = 6'h07;
  localparam logic [5:0] OFS_TIM = 6'h08;
  localparam logic [5:0] OFS_OCM = 6'h09;
  localparam logic [5:0] OFS_OCT = 6'h0a;

  // Reset values
  localparam logic [7:0] RST_LSG = 8'hff;
  localparam logic [7:0] RST_TIM = 8'h20;
  localparam logic [7:0] RST_OCM = 8'h20;
  localparam logic [7:0] RST_OCT = 8'hdd;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // Field positions, low-side gate current register
  localparam int unsigned LSG_SRC_LSB = 4;
  localparam int unsigned LSG_SNK_LSB = 0;
  // Field positions, timing register
  localparam int unsigned TIM_MODE_LSB = 6;
  localparam int unsigned TIM_TDRV_LSB = 4;
  localparam int unsigned TIM_DEAD_LSB = 1;
  localparam int unsigned TIM_IND_BIT = 0;
  // Field positions, overcurrent monitor register
  localparam int unsigned OCM_MODE_LSB = 6;
  localparam int unsigned OCM_DG_LSB = 4;
  localparam int unsigned OCM_PD_LSB = 2;
  localparam int unsigned OCM_LVL_BIT = 1;
  localparam int unsigned OCM_IND_BIT = 0;

  // Monitor response modes
  typedef enum logic [1:0] {
    GDPC_RSP_LATCH = 2'h0,
    GDPC_RSP_CBC = 2'h1,
    GDPC_RSP_WARN = 2'h2,
    GDPC_RSP_OFF = 2'h3
  } gdpc_rsp_t;

  // Bridge control modes
  typedef enum logic [1:0] {
    GDPC_BRG_INDEP = 2'h0,
    GDPC_BRG_PHEN = 2'h1,
    GDPC_BRG_PWM = 2'h2,
    GDPC_BRG_SPLIT = 2'h3
  } gdpc_brg_t;

  // Post-fault pulldown selections and the sink codes they force
  localparam logic [1:0] PD_PROGRAMMED = 2'h0;
  localparam logic [1:0] PD_8MA = 2'h1;
  localparam logic [1:0] PD_31MA = 2'h2;
  localparam logic [1:0] PD_62MA = 2'h3;
  localparam logic [3:0] SNK_CODE_8MA = 4'h6;
  localparam logic [3:0] SNK_CODE_31MA = 4'hc;
  localparam logic [3:0] SNK_CODE_62MA = 4'hf;

  // Drive and blanking times in microseconds
  localparam int unsigned TDRV0_US = 96;
  localparam int unsigned TDRV1_US = 2;
  localparam int unsigned TDRV2_US = 4;
  localparam int unsigned TDRV3_US = 8;
  // Inserted dead times in nanoseconds
  localparam int unsigned DEAD1_NS = 250;
  localparam int unsigned DEAD2_NS = 500;
  localparam int unsigned DEAD3_NS = 750;
  localparam int unsigned DEAD4_NS = 1000;
  localparam int unsigned DEAD5_NS = 2000;
  localparam int unsigned DEAD6_NS = 4000;
  localparam int unsigned DEAD7_NS = 8000;
  // Overcurrent deglitch times in microseconds
  localparam int unsigned DG0_US = 1;
  localparam int unsigned DG1_US = 2;
  localparam int unsigned DG2_US = 4;
  localparam int unsigned DG3_US = 8;

  // Cycle counts; minimum times round up
  localparam int unsigned CYC_W = 14;
  localparam int unsigned TDRV0_CYC_DEF = TDRV0_US * CLK_MHZ;
  localparam logic [13:0] TDRV1_CYC = 14'(TDRV1_US * CLK_MHZ);
  localparam logic [13:0] TDRV2_CYC = 14'(TDRV2_US * CLK_MHZ);
  localparam logic [13:0] TDRV3_CYC = 14'(TDRV3_US * CLK_MHZ);
  localparam logic [13:0] DEAD0_CYC = 14'h0000;
  localparam logic [13:0] DEAD1_CYC = 14'((DEAD1_NS * CLK_MHZ + 999) / 1000);
  localparam logic [13:0] DEAD2_CYC = 14'((DEAD2_NS * CLK_MHZ + 999) / 1000);
  localparam logic [13:0] DEAD3_CYC = 14'((DEAD3_NS * CLK_MHZ + 999) / 1000);
  localparam logic [13:0] DEAD4_CYC = 14'((DEAD4_NS * CLK_MHZ + 999) / 1000);
  localparam logic [13:0] DEAD5_CYC = 14'((DEAD5_NS * CLK_MHZ + 999) / 1000);
  localparam logic [13:0] DEAD6_CYC = 14'((DEAD6_NS * CLK_MHZ + 999) / 1000);
  localparam logic [13:0] DEAD7_CYC = 14'((DEAD7_NS * CLK_MHZ + 999) / 1000);
  localparam logic [13:0] DG0_CYC = 14'(DG0_US * CLK_MHZ);
  localparam logic [13:0] DG1_CYC = 14'(DG1_US * CLK_MHZ);
  localparam logic [13:0] DG2_CYC = 14'(DG2_US * CLK_MHZ);
  localparam logic [13:0] DG3_CYC = 14'(DG3_US * CLK_MHZ);
  // Gate fault comparator is qualified for one cycle only
  localparam logic [13:0] GATE_FILT_CYC = 14'h0001;

  // Settings handed to one fault monitor
  typedef struct packed {
    gdpc_rsp_t mode;
    logic local_en;
    logic [13:0] filt_cyc;
  } gdpc_flt_cfg_t;

  // One register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } gdpc_req_t;

endpackage : gdpc_pkg

// ### core/gdpc_fault_unit.sv
// Fault monitor response: filter, latch, cycle-by-cycle, warning and shutdown scope
`timescale 1ns/10ps
module gdpc_fault_unit import gdpc_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire gdpc_flt_cfg_t cfg,
  input wire logic [1:0] raw,
  input wire logic ctrl_edge,
  input wire logic clear,
  output logic [1:0] fault,
  output logic [1:0] warn,
  output logic [1:0] shutdown
);

  logic [1:0][13:0] cnt_q;
  logic [1:0][13:0] cnt_d;
  logic [1:0] det;
  logic [1:0] flt_q;
  logic [1:0] flt_d;
  logic [1:0] wrn_q;
  logic [1:0] wrn_d;

  // One filter and flag pair per half-bridge
  for (genvar i = 0; i < 2; i++) begin : g_hb
    // Next filter count and flags; a new detection wins over any clear
    always_comb begin
      det[i] = raw[i] && ((15'(cnt_q[i]) + 15'h0001) >= 15'(cfg.filt_cyc));
      cnt_d[i] = cnt_q[i];
      if (!raw[i] || cfg.mode == GDPC_RSP_OFF) begin
        cnt_d[i] = 14'h0000;
      end else if (!det[i]) begin
        cnt_d[i] = cnt_q[i] + 14'h0001;
      end
      case (cfg.mode)
        GDPC_RSP_LATCH: begin
          flt_d[i] = det[i] | (flt_q[i] & ~clear);
          wrn_d[i] = wrn_q[i] & ~clear;
        end
        GDPC_RSP_CBC: begin
          flt_d[i] = det[i] | (flt_q[i] & ~ctrl_edge);
          wrn_d[i] = wrn_q[i] & ~clear;
        end
        GDPC_RSP_WARN: begin
          flt_d[i] = 1'b0;
          wrn_d[i] = det[i] | (wrn_q[i] & ~clear);
        end
        default: begin
          flt_d[i] = 1'b0;
          wrn_d[i] = 1'b0;
        end
      endcase
    end

    // Filter and flag registers
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        cnt_q[i] <= 14'h0000;
        flt_q[i] <= 1'b0;
        wrn_q[i] <= 1'b0;
      end else begin
        cnt_q[i] <= cnt_d[i];
        flt_q[i] <= flt_d[i];
        wrn_q[i] <= wrn_d[i];
      end
    end
  end

  // Local scope stops only the faulted half-bridge, else both
  assign fault = flt_q;
  assign warn = wrn_q;
  assign shutdown = cfg.local_en ? flt_q : {2{|flt_q}};

  property p_cbc_release;
    @(posedge clk) disable iff (!rst_n)
      (cfg.mode == GDPC_RSP_CBC && flt_q[0] && ctrl_edge && !det[0]) |=> !flt_q[0];
  endproperty
  a_cbc_release: assert property (p_cbc_release) else $error("cbc fault not released");

  property p_latch_hold;
    @(posedge clk) disable iff (!rst_n)
      (cfg.mode == GDPC_RSP_LATCH && flt_q[1] && !clear) |=> flt_q[1];
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched fault lost");

endmodule : gdpc_fault_unit

// ### core/gdpc_bank.sv
// Gate drive protection configuration bank with fault response logic
// Summary of operation
// - Bits 7-4 of 0x7 set low-side source code
// - Bits 3-0 of 0x7 set low-side sink code
// - Gate fault mode: latch, cycle, warn, off
// - Timing bits 5-4 set drive and blanking time
// - Timing bits 3-1 insert dead time up to 8us
// - Gate fault local shutdown in bridge modes 00/11
// - Overcurrent mode: latch, cycle, warn, off
// - Overcurrent bits 5-4 select deglitch time
// - Post-fault pulldown overrides programmed sink current
// - Bit 1 selects gate threshold 1.4V or 1.0V
// - Overcurrent local shutdown in bridge modes 00/11
// - Timing register 0x8 resets to 0x20, read/write
// - Overcurrent register 0x9 resets to 0x20, read/write
// - Register 0xA resets 0xDD, 0x7 resets 0xFF
// - Bridge mode decodes independent, phase, PWM, split
`timescale 1ns/10ps
module gdpc_bank import gdpc_pkg::*; #(
  parameter logic [13:0] TDRV0_CYC = 14'(TDRV0_CYC_DEF)
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [5:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic REG_READ_VALID,
  input wire logic [1:0] BRIDGE_MODE,
  input wire logic CTRL_EDGE,
  input wire logic FAULT_CLEAR,
  input wire logic [1:0] GATE_FAULT_RAW,
  input wire logic [1:0] OC_FAULT_RAW,
  output logic [3:0] LS_SOURCE_CODE,
  output logic [1:0][3:0] LS_SINK_CODE,
  output logic [13:0] DRIVE_BLANK_CYCLES,
  output logic [13:0] DEAD_TIME_CYCLES,
  output logic GATE_THRESHOLD_LOW,
  output logic [7:0] OC_THRESHOLD,
  output logic [1:0] GATE_FAULT,
  output logic [1:0] GATE_WARN,
  output logic [1:0] OC_FAULT,
  output logic [1:0] OC_WARN,
  output logic [1:0] HB_SHUTDOWN
);

  // Independent scope is allowed only in these bridge modes
  function automatic logic local_mode(input logic [1:0] brg);
    case (gdpc_brg_t'(brg))
      GDPC_BRG_INDEP: local_mode = 1'b1;
      GDPC_BRG_SPLIT: local_mode = 1'b1;
      GDPC_BRG_PHEN: local_mode = 1'b0;
      GDPC_BRG_PWM: local_mode = 1'b0;
      default: local_mode = 1'b0;
    endcase
  endfunction : local_mode

  // Drive and blanking time code to cycles
  function automatic logic [13:0] tdrv_cycles(input logic [1:0] code);
    case (code)
      2'h0: tdrv_cycles = TDRV0_CYC;
      2'h1: tdrv_cycles = TDRV1_CYC;
      2'h2: tdrv_cycles = TDRV2_CYC;
      default: tdrv_cycles = TDRV3_CYC;
    endcase
  endfunction : tdrv_cycles

  // Dead time code to cycles
  function automatic logic [13:0] dead_cycles(input logic [2:0] code);
    case (code)
      3'h0: dead_cycles = DEAD0_CYC;
      3'h1: dead_cycles = DEAD1_CYC;
      3'h2: dead_cycles = DEAD2_CYC;
      3'h3: dead_cycles = DEAD3_CYC;
      3'h4: dead_cycles = DEAD4_CYC;
      3'h5: dead_cycles = DEAD5_CYC;
      3'h6: dead_cycles = DEAD6_CYC;
      default: dead_cycles = DEAD7_CYC;
    endcase
  endfunction : dead_cycles

  // Deglitch code to cycles
  function automatic logic [13:0] dg_cycles(input logic [1:0] code);
    case (code)
      2'h0: dg_cycles = DG0_CYC;
      2'h1: dg_cycles = DG1_CYC;
      2'h2: dg_cycles = DG2_CYC;
      default: dg_cycles = DG3_CYC;
    endcase
  endfunction : dg_cycles

  // Sink code in force after an overcurrent fault
  function automatic logic [3:0] pd_sink(input logic [1:0] sel, input logic [3:0] prog);
    case (sel)
      PD_PROGRAMMED: pd_sink = prog;
      PD_8MA: pd_sink = SNK_CODE_8MA;
      PD_31MA: pd_sink = SNK_CODE_31MA;
      PD_62MA: pd_sink = SNK_CODE_62MA;
      default: pd_sink = prog;
    endcase
  endfunction : pd_sink

  gdpc_req_t req;
  logic [7:0] lsg_q;
  logic [7:0] lsg_d;
  logic [7:0] tim_q;
  logic [7:0] tim_d;
  logic [7:0] ocm_q;
  logic [7:0] ocm_d;
  logic [7:0] oct_q;
  logic [7:0] oct_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [3:0] low_source_current_code;
  logic [3:0] low_sink_current_code;
  gdpc_rsp_t gate_fault_response;
  logic [1:0] drive_blank_time;
  logic [2:0] inserted_dead_time;
  logic gate_fault_local_shutdown;
  gdpc_rsp_t overcurrent_response;
  logic [1:0] overcurrent_deglitch;
  logic [1:0] post_fault_pulldown;
  logic gate_threshold_select;
  logic overcurrent_local_shutdown;
  gdpc_flt_cfg_t gate_cfg;
  gdpc_flt_cfg_t oc_cfg;
  logic [1:0] gate_flt;
  logic [1:0] gate_wrn;
  logic [1:0] gate_sd;
  logic [1:0] oc_flt;
  logic [1:0] oc_wrn;
  logic [1:0] oc_sd;
  logic [1:0][3:0] sink_q;
  logic [1:0][3:0] sink_d;
  logic [13:0] tdrv_q;
  logic [13:0] tdrv_d;
  logic [13:0] dead_q;
  logic [13:0] dead_d;
  logic [1:0] sd_q;
  logic [1:0] sd_d;

  assign req = '{wr: REG_WR, rd: REG_RD, addr: REG_ADDR, wdata: REG_WDATA};

  // Register writes and reads; a read returns the value before a same-cycle write
  always_comb begin
    lsg_d = lsg_q;
    tim_d = tim_q;
    ocm_d = ocm_q;
    oct_d = oct_q;
    if (req.wr) begin
      case (req.addr)
        OFS_LSG: lsg_d = req.wdata;
        OFS_TIM: tim_d = req.wdata;
        OFS_OCM: ocm_d = req.wdata;
        OFS_OCT: oct_d = req.wdata;
        default: lsg_d = lsg_q;
      endcase
    end
    rvalid_d = req.rd;
    rdata_d = rdata_q;
    if (req.rd) begin
      case (req.addr)
        OFS_LSG: rdata_d = lsg_q;
        OFS_TIM: rdata_d = tim_q;
        OFS_OCM: rdata_d = ocm_q;
        OFS_OCT: rdata_d = oct_q;
        default: rdata_d = RD_UNMAPPED;
      endcase
    end
  end

  // Register state with synchronous reset values
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      lsg_q <= RST_LSG;
      tim_q <= RST_TIM;
      ocm_q <= RST_OCM;
      oct_q <= RST_OCT;
      rdata_q <= RD_UNMAPPED;
      rvalid_q <= 1'b0;
    end else begin
      lsg_q <= lsg_d;
      tim_q <= tim_d;
      ocm_q <= ocm_d;
      oct_q <= oct_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // Field views of the registers
  assign low_source_current_code = lsg_q[LSG_SRC_LSB +: 4];
  assign low_sink_current_code = lsg_q[LSG_SNK_LSB +: 4];
  assign gate_fault_response = gdpc_rsp_t'(tim_q[TIM_MODE_LSB +: 2]);
  assign drive_blank_time = tim_q[TIM_TDRV_LSB +: 2];
  assign inserted_dead_time = tim_q[TIM_DEAD_LSB +: 3];
  assign gate_fault_local_shutdown = tim_q[TIM_IND_BIT];
  assign overcurrent_response = gdpc_rsp_t'(ocm_q[OCM_MODE_LSB +: 2]);
  assign overcurrent_deglitch = ocm_q[OCM_DG_LSB +: 2];
  assign post_fault_pulldown = ocm_q[OCM_PD_LSB +: 2];
  assign gate_threshold_select = ocm_q[OCM_LVL_BIT];
  assign overcurrent_local_shutdown = ocm_q[OCM_IND_BIT];

  // Monitor settings; independent scope needs both the enable and a suitable bridge mode
  assign gate_cfg = '{mode: gate_fault_response,
                      local_en: gate_fault_local_shutdown && local_mode(BRIDGE_MODE),
                      filt_cyc: GATE_FILT_CYC};
  assign oc_cfg = '{mode: overcurrent_response,
                    local_en: overcurrent_local_shutdown && local_mode(BRIDGE_MODE),
                    filt_cyc: dg_cycles(overcurrent_deglitch)};

  gdpc_fault_unit u_gate_mon (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .cfg(gate_cfg),
    .raw(GATE_FAULT_RAW),
    .ctrl_edge(CTRL_EDGE),
    .clear(FAULT_CLEAR),
    .fault(gate_flt),
    .warn(gate_wrn),
    .shutdown(gate_sd)
  );

  gdpc_fault_unit u_oc_mon (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .cfg(oc_cfg),
    .raw(OC_FAULT_RAW),
    .ctrl_edge(CTRL_EDGE),
    .clear(FAULT_CLEAR),
    .fault(oc_flt),
    .warn(oc_wrn),
    .shutdown(oc_sd)
  );

  // Decoded drive settings for the gate driver
  always_comb begin
    tdrv_d = tdrv_cycles(drive_blank_time);
    dead_d = dead_cycles(inserted_dead_time);
    sd_d = gate_sd | oc_sd;
    for (int i = 0; i < 2; i++) begin
      sink_d[i] = oc_sd[i] ? pd_sink(post_fault_pulldown, low_sink_current_code)
                           : low_sink_current_code;
    end
  end

  // Decoded settings registers
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      tdrv_q <= TDRV2_CYC;
      dead_q <= DEAD0_CYC;
      sd_q <= 2'h0;
      sink_q <= {2{RST_LSG[LSG_SNK_LSB +: 4]}};
    end else begin
      tdrv_q <= tdrv_d;
      dead_q <= dead_d;
      sd_q <= sd_d;
      sink_q <= sink_d;
    end
  end

  assign REG_RDATA = rdata_q;
  assign REG_READ_VALID = rvalid_q;
  assign LS_SOURCE_CODE = low_source_current_code;
  assign LS_SINK_CODE = sink_q;
  assign DRIVE_BLANK_CYCLES = tdrv_q;
  assign DEAD_TIME_CYCLES = dead_q;
  assign GATE_THRESHOLD_LOW = gate_threshold_select;
  assign OC_THRESHOLD = oct_q;
  assign GATE_FAULT = gate_flt;
  assign GATE_WARN = gate_wrn;
  assign OC_FAULT = oc_flt;
  assign OC_WARN = oc_wrn;
  assign HB_SHUTDOWN = sd_q;

  // Checks on the bank
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  property p_reset_values;
    disable iff (1'b0)
      !RST_N |=> (lsg_q == 8'hff && oct_q == 8'hdd && LS_SOURCE_CODE == 4'hf);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("bad reset value");

  property p_tim_read;
    disable iff (1'b0)
      (!RST_N ##1 RST_N ##1 (RST_N && REG_RD && REG_ADDR == 6'h08)) |=> REG_RDATA == 8'h20;
  endproperty
  a_tim_read: assert property (p_tim_read) else $error("timing reg reset read");

  property p_ocm_rw;
    (REG_WR && REG_ADDR == 6'h09) ##1 (REG_RD && REG_ADDR == 6'h09 && !REG_WR)
      |=> REG_RDATA == $past(REG_WDATA, 2);
  endproperty
  a_ocm_rw: assert property (p_ocm_rw) else $error("overcurrent reg readback");

  property p_sink_write;
    (REG_WR && REG_ADDR == 6'h07 && oc_sd == 2'h0) ##1 (oc_sd == 2'h0)
      |=> LS_SINK_CODE[0] == $past(REG_WDATA[3:0], 2);
  endproperty
  a_sink_write: assert property (p_sink_write) else $error("sink code not applied");

  property p_tdrv_2us;
    (tim_q[5:4] == 2'h1) |=> DRIVE_BLANK_CYCLES == 14'd250;
  endproperty
  a_tdrv_2us: assert property (p_tdrv_2us) else $error("drive time 2us wrong");

  property p_dead_8us;
    (tim_q[3:1] == 3'h7) |=> DEAD_TIME_CYCLES == 14'd1000;
  endproperty
  a_dead_8us: assert property (p_dead_8us) else $error("dead time 8us wrong");

  property p_gate_global;
    (gate_flt == 2'h1 && !(tim_q[0] && local_mode(BRIDGE_MODE))) |=> HB_SHUTDOWN == 2'h3;
  endproperty
  a_gate_global: assert property (p_gate_global) else $error("gate fault not global");

  property p_oc_local;
    (oc_flt == 2'h2 && gate_flt == 2'h0 && ocm_q[0] && BRIDGE_MODE == 2'h3)
      |=> HB_SHUTDOWN == 2'h2;
  endproperty
  a_oc_local: assert property (p_oc_local) else $error("oc fault not local");

  property p_pulldown_31;
    (oc_sd[1] && ocm_q[3:2] == 2'h2) |=> LS_SINK_CODE[1] == 4'hc;
  endproperty
  a_pulldown_31: assert property (p_pulldown_31) else $error("pulldown not 31mA");

  property p_oc_off;
    (ocm_q[7:6] == 2'h3) [*2] |-> (OC_FAULT == 2'h0 && OC_WARN == 2'h0);
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("disabled monitor active");

  property p_oc_deglitch;
    (ocm_q[5:4] == 2'h0 && ocm_q[7:6] == 2'h0 && !OC_FAULT[0]) ##1 $rose(OC_FAULT[0])
      |-> $past(OC_FAULT_RAW[0], 125);
  endproperty
  a_oc_deglitch: assert property (p_oc_deglitch) else $error("deglitch too short");

  property p_threshold;
    ocm_q[1] |-> GATE_THRESHOLD_LOW;
  endproperty
  a_threshold: assert property (p_threshold) else $error("threshold select lost");

  c_oc_latch: cover property (ocm_q[7:6] == 2'h0 ##1 $rose(OC_FAULT[0]));
  c_gate_cbc: cover property (tim_q[7:6] == 2'h1 ##1 $fell(GATE_FAULT[0]));
  c_local_sd: cover property (HB_SHUTDOWN == 2'h2);
  c_warn: cover property ($rose(OC_WARN[0]));

endmodule : gdpc_bank

// ### tb/gdpc_host_model.sv
// Host model: issues register writes and reads into the bank
`timescale 1ns/10ps
module gdpc_host_model import gdpc_pkg::*; (
  input wire logic clk,
  input wire logic [7:0] rdata,
  input wire logic read_valid,
  output gdpc_req_t req
);
  // Idle request at time zero
  initial begin
    req = '0;
  end

  // One write strobe across one sampling edge
  task automatic wr(input logic [5:0] addr, input logic [7:0] data);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(negedge clk);
    req.wr = 1'b0;
    req.wdata = ~data;  // Released data shows no stale value
  endtask : wr

  // One read strobe; valid stands only in the cycle after the strobe edge, so look from there
  task automatic rd(input logic [5:0] addr, output logic [7:0] data, output logic ok);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    ok = 1'b0;
    data = 8'h00;
    repeat (4) begin
      @(negedge clk);
      req.rd = 1'b0;
      if (!ok && read_valid === 1'b1) begin
        ok = 1'b1;
        data = rdata;
      end
    end
  endtask : rd

  // Write then read of one offset on back-to-back edges
  task automatic wr_rd(input logic [5:0] addr, input logic [7:0] wd, output logic [7:0] data,
                       output logic ok);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: wd};
    rd(addr, data, ok);
  endtask : wr_rd
endmodule : gdpc_host_model

// ### tb/tb_top.sv
// Testbench: register readback, field decode and fault response of the bank
`timescale 1ns/10ps
module tb_top import gdpc_pkg::*; ();
  logic clk;
  logic rst_n;
  logic [1:0] bmode;
  logic ctrl_edge;
  logic fclr;
  logic [1:0] graw;
  logic [1:0] oraw;
  gdpc_req_t req;
  logic [7:0] rdata;
  logic rvalid;
  logic [3:0] src;
  logic [1:0][3:0] snk;
  logic [13:0] blank;
  logic [13:0] dead;
  logic thr;
  logic [7:0] octh;
  logic [1:0] gflt;
  logic [1:0] gwrn;
  logic [1:0] oflt;
  logic [1:0] owrn;
  logic [1:0] shut;
  int fail_count;
  int samples_checked;

  // Bank with a short longest drive time
  gdpc_bank #(.TDRV0_CYC(14'd20)) i_gdpc_bank (
    .CORE_CLK(clk), .RST_N(rst_n), .REG_WR(req.wr), .REG_RD(req.rd),
    .REG_ADDR(req.addr), .REG_WDATA(req.wdata), .REG_RDATA(rdata), .REG_READ_VALID(rvalid),
    .BRIDGE_MODE(bmode), .CTRL_EDGE(ctrl_edge), .FAULT_CLEAR(fclr),
    .GATE_FAULT_RAW(graw), .OC_FAULT_RAW(oraw), .LS_SOURCE_CODE(src), .LS_SINK_CODE(snk),
    .DRIVE_BLANK_CYCLES(blank), .DEAD_TIME_CYCLES(dead), .GATE_THRESHOLD_LOW(thr),
    .OC_THRESHOLD(octh), .GATE_FAULT(gflt), .GATE_WARN(gwrn), .OC_FAULT(oflt),
    .OC_WARN(owrn), .HB_SHUTDOWN(shut));

  // Host on the register port
  gdpc_host_model i_gdpc_host_model (.clk(clk), .rdata(rdata), .read_valid(rvalid), .req(req));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Expected drive and blanking cycles with the short longest setting
  function automatic logic [13:0] exp_blank(input logic [1:0] c);
    return (c == 2'h0) ? 14'd20 : 14'(250 << (c - 1));
  endfunction : exp_blank

  // Expected dead time cycles, rounded up
  function automatic logic [13:0] exp_dead(input logic [2:0] c);
    int ns;
    ns = (c < 3'h5) ? 250 * c : 1000 << (c - 4);
    return 14'((ns * 125 + 999) / 1000);
  endfunction : exp_dead

  // Expected sink code while the overcurrent pulldown applies
  function automatic logic [3:0] exp_sink(input logic [1:0] pd, input logic [3:0] prog);
    case (pd)
      2'h1: return 4'h6;
      2'h2: return 4'hc;
      2'h3: return 4'hf;
      default: return prog;
    endcase
  endfunction : exp_sink

  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // Counted comparison
  task automatic chk(input string name, input logic [13:0] exp, input logic [13:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Write and read through the host
  task automatic w(input logic [5:0] a, input logic [7:0] d);
    i_gdpc_host_model.wr(a, d);
  endtask : w

  task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    i_gdpc_host_model.rd(a, d, ok);
    if (!ok) begin
      fail_count++;
      $display("unexpected read_valid expected 1 seen 0");
      finish_test();
    end else begin
      chk("read_data", 14'(exp), 14'(d));
    end
  endtask : rdchk

  // Raise one comparator on one half-bridge for n samples
  task automatic fire(input bit oc, input int hb, input int n);
    if (oc) oraw[hb] = 1'b1;
    else graw[hb] = 1'b1;
    repeat (n) @(negedge clk);
    oraw = 2'h0;
    graw = 2'h0;
    repeat (3) @(negedge clk);
  endtask : fire

  // One-cycle pulse on the control edge or the clear input
  task automatic pulse(input bit edge_in);
    if (edge_in) ctrl_edge = 1'b1;
    else fclr = 1'b1;
    @(negedge clk);
    ctrl_edge = 1'b0;
    fclr = 1'b0;
    repeat (3) @(negedge clk);
  endtask : pulse

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    finish_test();
  end

  // Main sequence
  initial begin
    logic [7:0] lsg;
    logic [7:0] tim;
    logic [7:0] ocm;
    logic [7:0] oct;
    logic [7:0] rb;
    logic ok;
    fail_count = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    bmode = 2'h2;
    ctrl_edge = 1'b0;
    fclr = 1'b0;
    graw = 2'h0;
    oraw = 2'h0;
    void'($urandom(43147));
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    rdchk(OFS_TIM, 8'h20);
    rdchk(OFS_LSG, 8'hff);
    rdchk(OFS_OCM, 8'h20);
    rdchk(OFS_OCT, 8'hdd);
    chk("blank", exp_blank(2'h2), blank);
    // Random contents, every timing code, readback and decode
    for (int i = 0; i < 8; i++) begin
      lsg = 8'($urandom());
      tim = {2'($urandom()), 2'(i), 3'(i), 1'($urandom())};
      ocm = 8'($urandom());
      oct = 8'($urandom());
      w(OFS_LSG, lsg);
      w(OFS_TIM, tim);
      w(OFS_OCM, ocm);
      w(OFS_OCT, oct);
      w(6'h0b, 8'($urandom()));
      rdchk(OFS_LSG, lsg);
      rdchk(OFS_TIM, tim);
      rdchk(OFS_OCM, ocm);
      rdchk(OFS_OCT, oct);
      rdchk(6'h0b, 8'h00);
      chk("source", 14'(lsg[7:4]), 14'(src));
      chk("sink", 14'(lsg[3:0] * 8'h11), 14'(snk));
      chk("blank", exp_blank(tim[5:4]), blank);
      chk("dead", exp_dead(tim[3:1]), dead);
      chk("threshold", 14'(ocm[1]), 14'(thr));
      chk("oc_threshold", 14'(oct), 14'(octh));
    end
    // Write then read of one offset on back-to-back edges
    ocm = 8'($urandom());
    i_gdpc_host_model.wr_rd(OFS_OCM, ocm, rb, ok);
    chk("read_valid", 14'h0001, 14'(ok));
    chk("read_data", 14'(ocm), 14'(rb));
    // Every response mode of both monitors, then host clear and control edge
    for (int oc = 0; oc < 2; oc++) begin
      for (int m = 0; m < 4; m++) begin
        w(OFS_TIM, oc ? 8'hc0 : {2'(m), 6'h20});
        w(OFS_OCM, oc ? {2'(m), 6'h00} : 8'hc0);
        fire(oc[0], 0, 130);
        chk("fault", (m < 2) ? 14'h1 : 14'h0, 14'(oc ? oflt : gflt));
        chk("warn", (m == 2) ? 14'h1 : 14'h0, 14'(oc ? owrn : gwrn));
        chk("shutdown", (m < 2) ? 14'h3 : 14'h0, 14'(shut));
        pulse(1'b0);
        chk("fault", (m == 1) ? 14'h1 : 14'h0, 14'(oc ? oflt : gflt));
        pulse(1'b1);
        chk("shutdown", 14'h0, 14'(shut));
      end
    end
    // Deglitch length and post-fault pulldown per code
    for (int c = 0; c < 4; c++) begin
      lsg = 8'($urandom());
      w(OFS_LSG, lsg);
      w(OFS_OCM, {2'h0, 2'(c), 2'(c), 2'h0});
      oraw[0] = 1'b1;
      repeat ((125 << c) - 1) @(negedge clk);
      chk("early_fault", 14'h0, 14'(oflt));
      repeat (3) @(negedge clk);
      chk("fault", 14'h1, 14'(oflt));
      chk("sink", 14'(exp_sink(2'(c), lsg[3:0]) * 8'h11), 14'(snk));
      fire(1'b1, 0, 1);
      pulse(1'b0);
      chk("fault", 14'h0, 14'(oflt));
      chk("sink", 14'(lsg[3:0] * 8'h11), 14'(snk));
    end
    // Local or whole-bridge shutdown for every bridge control mode
    for (int oc = 0; oc < 2; oc++) begin
      for (int b = 0; b < 4; b++) begin
        bmode = 2'(b);
        w(OFS_TIM, 8'h21);
        w(OFS_OCM, 8'h01);
        fire(oc[0], 1, 130);
        chk("shutdown", (b == 0 || b == 3) ? 14'h2 : 14'h3, 14'(shut));
        pulse(1'b0);
      end
    end
    finish_test();
  end
endmodule : tb_top
